// >>> inc/swcd_pkg.sv
// What this block does
// - Command byte is eight bits: top bit selects write or read, rest address.
// - Selector one: next received byte is stored into the addressed register.
// - Selector zero: device transmits current contents of the addressed register.
// - Register address comes from command bits six down to zero, 128 bytes.
// - A 16-bit register pair is refreshed no more often than once per 0.8 s.
// - Command and data bytes travel least significant bit first, both directions.
// - After a read command the device waits the response delay, then drives data.
package swcd_pkg;
  // ----------------------------------------------------------------
  // command byte layout
  // ----------------------------------------------------------------
  localparam int CMD_W = 8;
  localparam int WR_BIT = 7;
  localparam int ADDR_MSB = 6;
  localparam int ADDR_LSB = 0;
  localparam int ADDR_W = ADDR_MSB - ADDR_LSB + 1;
  localparam int DATA_W = 8;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic PAIR_HI_OFS = 1'b1; // high byte of a pair sits at the odd address
  // ----------------------------------------------------------------
  // timing, times in ns and counts at the 50 MHz clock
  // ----------------------------------------------------------------
  localparam int CLK_NS = 20;
  localparam int T_SPLIT_NS = 100000;      // host low shorter than this reads as one
  localparam int T_BREAK_NS = 190000;      // least low time taken as a break
  localparam int T_RESP_NS = 190000;       // response delay before the first data bit
  localparam int T_DW1_NS = 40000;         // device low time for a one
  localparam int T_DW0_NS = 120000;        // device low time for a zero
  localparam int T_CYCD_NS = 200000;       // device bit cycle
  localparam int T_PAIR_NS = 800000000;    // least spacing of pair refreshes
  localparam int SPLIT_CYC = (T_SPLIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int BREAK_CYC = (T_BREAK_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESP_CYC = (T_RESP_NS + CLK_NS - 1) / CLK_NS;
  localparam int DW1_CYC = (T_DW1_NS + CLK_NS - 1) / CLK_NS;
  localparam int DW0_CYC = (T_DW0_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYCD_CYC = (T_CYCD_NS + CLK_NS - 1) / CLK_NS;
  localparam int PAIR_CYC = (T_PAIR_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 16;
  localparam int PAIR_CNT_W = 26;
endpackage : swcd_pkg

// >>> hw/reg_byte_ram.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// byte register store, one write port, registered read
// ----------------------------------------------------------------
module reg_byte_ram #(
  parameter int ADDR_W = 7,
  parameter int DATA_W = 8
) (
  // clock
  input wire logic clk,
  input wire logic ce,
  // write port
  input wire logic we,
  input wire logic [ADDR_W-1:0] waddr,
  input wire logic [DATA_W-1:0] wdata,
  // read port
  input wire logic [ADDR_W-1:0] raddr,
  output logic [DATA_W-1:0] rdata
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // no reset on the array: it would cost a clear cycle per word
  always_ff @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule : reg_byte_ram

// >>> hw/single_wire_command_decoder.sv
`timescale 1ns/1ps
module single_wire_command_decoder #(
  parameter int SPLIT_CYC = swcd_pkg::SPLIT_CYC,
  parameter int BREAK_CYC = swcd_pkg::BREAK_CYC,
  parameter int RESP_CYC = swcd_pkg::RESP_CYC,
  parameter int DW1_CYC = swcd_pkg::DW1_CYC,
  parameter int DW0_CYC = swcd_pkg::DW0_CYC,
  parameter int CYCD_CYC = swcd_pkg::CYCD_CYC,
  parameter int PAIR_CYC = swcd_pkg::PAIR_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // single-wire open-drain pin
  input wire logic line_in,
  output logic line_out,
  output logic line_oe,
  // gauge core pair refresh
  input wire logic core_pair_we,
  input wire logic [swcd_pkg::ADDR_W-2:0] core_pair_addr,
  input wire logic [2*swcd_pkg::DATA_W-1:0] core_pair_data,
  output logic core_ready,
  // host write notification
  output logic host_wr_valid,
  output logic [swcd_pkg::ADDR_W-1:0] host_wr_addr,
  output logic [swcd_pkg::DATA_W-1:0] host_wr_data
);
  typedef enum logic [2:0] {st_idle, st_rx_low, st_brk_wait, st_resp, st_tx} state_t;

  state_t state, next_state;
  logic line_s1, line_s2, line_s3, line, line_d;
  logic [swcd_pkg::CNT_W-1:0] cnt;
  logic [2:0] bit_cnt, tx_cnt;
  logic data_phase;
  logic [swcd_pkg::CMD_W-1:0] shreg, cmd, tx_shift;
  logic [swcd_pkg::DATA_W-1:0] rdata;
  logic [1:0] pend, next_pend;
  logic [swcd_pkg::PAIR_CNT_W-1:0] pair_cnt, next_pair_cnt;
  logic [swcd_pkg::ADDR_W-2:0] pair_addr;
  logic [2*swcd_pkg::DATA_W-1:0] pair_data;
  logic mem_we;
  logic [swcd_pkg::ADDR_W-1:0] mem_waddr;
  logic [swcd_pkg::DATA_W-1:0] mem_wdata;

  // ----------------------------------------------------------------
  // pin synchroniser and glitch filter
  // ----------------------------------------------------------------
  // only s2 and s3 are compared; s1 may be metastable
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      line_s1 <= 1'b1;
      line_s2 <= 1'b1;
      line_s3 <= 1'b1;
      line <= 1'b1;
      line_d <= 1'b1;
    end else if (ce) begin
      line_s1 <= line_in;
      line_s2 <= line_s1;
      line_s3 <= line_s2;
      if (line_s2 == line_s3) begin
        line <= line_s3;
      end
      line_d <= line;
    end
  end

  wire fall = line_d & ~line;
  wire rise = ~line_d & line;
  wire rx_bit = (cnt < swcd_pkg::CNT_W'(SPLIT_CYC)); // short low is a one
  wire [swcd_pkg::CMD_W-1:0] rx_byte = {rx_bit, shreg[swcd_pkg::CMD_W-1:1]};
  wire brk = (state == st_rx_low) && !line && (cnt == swcd_pkg::CNT_W'(BREAK_CYC - 1));
  wire byte_done = (state == st_rx_low) && rise && (bit_cnt == swcd_pkg::BIT_LAST);
  wire host_we = byte_done && data_phase;
  wire is_read = byte_done && !data_phase && !rx_byte[swcd_pkg::WR_BIT];
  wire bit_end = (state == st_tx) && (cnt == swcd_pkg::CNT_W'(CYCD_CYC - 1));

  // ----------------------------------------------------------------
  // serial engine state
  // ----------------------------------------------------------------
  // a host break during a device bit is ignored, the line is ours then
  always_comb begin
    next_state = state;
    case (state)
      st_idle: begin
        if (fall) begin
          next_state = st_rx_low;
        end
      end
      st_rx_low: begin
        if (brk) begin
          next_state = st_brk_wait;
        end else if (rise) begin
          next_state = is_read ? st_resp : st_idle;
        end
      end
      st_brk_wait: begin
        if (line) begin
          next_state = st_idle;
        end
      end
      st_resp: begin
        if (fall) begin
          next_state = st_rx_low;
        end else if (cnt == swcd_pkg::CNT_W'(RESP_CYC - 1)) begin
          next_state = st_tx;
        end
      end
      st_tx: begin
        if (bit_end && tx_cnt == swcd_pkg::BIT_LAST) begin
          next_state = st_idle;
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= st_idle;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // phase timer, restarts with each state and each device bit; saturates
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= '0;
    end else if (ce) begin
      if (next_state != state || bit_end) begin
        cnt <= '0;
      end else if (cnt != '1) begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // receive shifter and command decode
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt <= '0;
      data_phase <= 1'b0;
      shreg <= '0;
      cmd <= '0;
    end else if (ce) begin
      if (brk) begin
        bit_cnt <= '0; // partial byte dropped
        data_phase <= 1'b0;
      end else if (state == st_rx_low && rise) begin
        shreg <= rx_byte;
        bit_cnt <= bit_cnt + 1'b1;
        if (bit_cnt == swcd_pkg::BIT_LAST) begin
          if (!data_phase) begin
            cmd <= rx_byte;
            data_phase <= rx_byte[swcd_pkg::WR_BIT];
          end else begin
            data_phase <= 1'b0;
          end
        end
      end else if (state == st_resp && fall) begin
        bit_cnt <= '0; // host gave up waiting and starts over
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit shifter
  // ----------------------------------------------------------------
  // data is taken at the end of the delay, so a refresh during it is seen
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_shift <= '0;
      tx_cnt <= '0;
      line_oe <= 1'b0;
      line_out <= 1'b0;
    end else if (ce) begin
      if (state == st_resp) begin
        tx_shift <= rdata;
        tx_cnt <= '0;
      end else if (bit_end) begin
        tx_shift <= {1'b0, tx_shift[swcd_pkg::CMD_W-1:1]};
        tx_cnt <= tx_cnt + 1'b1;
      end
      line_oe <= (state == st_tx) &&
                 (cnt < swcd_pkg::CNT_W'(tx_shift[0] ? DW1_CYC : DW0_CYC));
      line_out <= 1'b0; // open drain: only ever pulls low
    end
  end

  // ----------------------------------------------------------------
  // pair refresh from the gauge core
  // ----------------------------------------------------------------
  wire accept = core_pair_we && core_ready;
  wire pair_full = (pair_cnt == swcd_pkg::PAIR_CNT_W'(PAIR_CYC - 1));

  // host writes win the port; the core pair waits a cycle
  always_comb begin
    next_pend = pend;
    next_pair_cnt = pair_full ? pair_cnt : pair_cnt + 1'b1;
    if (accept) begin
      next_pend = 2'h2;
      next_pair_cnt = '0;
    end else if (pend != 2'h0 && !host_we) begin
      next_pend = pend - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pend <= 2'h0;
      pair_cnt <= swcd_pkg::PAIR_CNT_W'(PAIR_CYC - 1);
      pair_addr <= '0;
      pair_data <= '0;
      core_ready <= 1'b0;
    end else if (ce) begin
      pend <= next_pend;
      pair_cnt <= next_pair_cnt;
      core_ready <= (next_pend == 2'h0) &&
                    (next_pair_cnt == swcd_pkg::PAIR_CNT_W'(PAIR_CYC - 1));
      if (accept) begin
        pair_addr <= core_pair_addr;
        pair_data <= core_pair_data;
      end
    end
  end

  // write port mux: high byte first, then low
  always_comb begin
    mem_we = host_we || (pend != 2'h0);
    mem_waddr = cmd[swcd_pkg::ADDR_MSB:swcd_pkg::ADDR_LSB];
    mem_wdata = rx_byte;
    if (!host_we) begin
      mem_waddr = {pair_addr, (pend == 2'h2) ? swcd_pkg::PAIR_HI_OFS : ~swcd_pkg::PAIR_HI_OFS};
      mem_wdata = (pend == 2'h2) ? pair_data[2*swcd_pkg::DATA_W-1:swcd_pkg::DATA_W]
                                 : pair_data[swcd_pkg::DATA_W-1:0];
    end
  end

  reg_byte_ram #(
    .ADDR_W(swcd_pkg::ADDR_W),
    .DATA_W(swcd_pkg::DATA_W)
  ) u_regs (
    .clk(clk),
    .ce(ce),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(cmd[swcd_pkg::ADDR_MSB:swcd_pkg::ADDR_LSB]),
    .rdata(rdata)
  );

  // host write notification toward the gauge core
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      host_wr_valid <= 1'b0;
      host_wr_addr <= '0;
      host_wr_data <= '0;
    end else if (ce) begin
      host_wr_valid <= host_we;
      if (host_we) begin
        host_wr_addr <= cmd[swcd_pkg::ADDR_MSB:swcd_pkg::ADDR_LSB];
        host_wr_data <= rx_byte;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n || !ce);

  a_write_selector: assert property (
    byte_done && !data_phase && rx_byte[swcd_pkg::WR_BIT] |=> data_phase && state == st_idle)
    else $error("write command did not open a data byte");
  a_write_notify: assert property (
    host_we |=> host_wr_valid && host_wr_addr == $past(cmd[6:0]) && host_wr_data == $past(rx_byte))
    else $error("host write not stored at command address");
  a_read_response: assert property (
    is_read |=> state == st_resp && !line_oe)
    else $error("read command did not start the response delay");
  a_addr_field: assert property (
    host_we |-> mem_we && mem_waddr == cmd[6:0])
    else $error("write address not taken from command bits");
  a_pair_spacing: assert property (
    accept |=> !core_ready [*8])
    else $error("pair refresh accepted again too soon");
  a_lsb_first: assert property (
    state == st_rx_low && rise |=> shreg[7] == $past(rx_bit))
    else $error("received bit not shifted in at the top");
  a_resp_delay: assert property (
    $rose(line_oe) && $past(tx_cnt) == 3'h0 |-> $past(state, 2) == st_resp)
    else $error("data driven without the response delay");
  a_break_abort: assert property (
    brk |=> bit_cnt == 3'h0 && !data_phase && !host_wr_valid)
    else $error("break did not abort the transfer");
  a_oe_in_tx: assert property (
    line_oe |-> $past(state) == st_tx)
    else $error("line driven outside a device bit");

  c_host_write: cover property (host_we);
  c_read_tx: cover property (state == st_resp ##1 state == st_tx);
  c_break: cover property (brk);
  c_pair_refresh: cover property (accept ##[1:4] pend == 2'h0);
endmodule : single_wire_command_decoder

// >>> tb/wire_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// host side of the single-wire link
// ----------------------------------------------------------------
module wire_host_model (
  // clock
  input wire logic clk,
  // resolved wire level and our pull-down
  input wire logic line,
  output logic pull_low
);
  initial pull_low = 1'b0;
  // callers enter on a falling edge; the pull-up restores high on release
  task automatic pulse(input int low, input int high);
    pull_low <= 1'b1;
    repeat (low) @(negedge clk);
    pull_low <= 1'b0;
    repeat (high) @(negedge clk);
  endtask : pulse
  // short low is a one, long low (still below a break) a zero
  task automatic send_byte(input logic [7:0] b, input int nbits);
    for (int i = 0; i < nbits; i++) begin
      pulse(b[i] ? 8 : 30, 12);
    end
  endtask : send_byte
  // long low restarts the serial engine
  task automatic send_break();
    pulse(120, 40);
  endtask : send_break
  // bounded waits so a silent device cannot hang us; idle after for the bit tail
  task automatic recv_byte(output logic [7:0] b, output int wait_cyc);
    int n;
    b = 8'h00;
    wait_cyc = 0;
    for (int i = 0; i < 8; i++) begin
      n = 0;
      while (line === 1'b1 && n < 400) begin
        @(negedge clk);
        n++;
      end
      if (i == 0) wait_cyc = n;
      n = 0;
      while (line === 1'b0 && n < 400) begin
        @(negedge clk);
        n++;
      end
      b[i] = (n < 16);
    end
    repeat (40) @(negedge clk);
  endtask : recv_byte
  task automatic read_reg(input logic [6:0] a, output logic [7:0] b, output int w);
    send_byte({1'b0, a}, 8);
    recv_byte(b, w);
  endtask : read_reg
  task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
    send_byte({1'b1, a}, 8);
    send_byte(d, 8);
  endtask : write_reg
  // high, low, high again; a changed high forces a fresh low, all well inside a pair period
  task automatic read16(input logic [5:0] idx, output logic [15:0] v);
    logic [7:0] first_high_byte, first_low_byte, second_high_byte, second_low_byte;
    int w;
    read_reg({idx, 1'b1}, first_high_byte, w);
    read_reg({idx, 1'b0}, first_low_byte, w);
    read_reg({idx, 1'b1}, second_high_byte, w);
    v = {first_high_byte, first_low_byte};
    if (second_high_byte !== first_high_byte) begin
      read_reg({idx, 1'b0}, second_low_byte, w);
      v = {second_high_byte, second_low_byte};
    end
  endtask : read16
endmodule : wire_host_model

// >>> tb/single_wire_command_decoder_tb.sv
`timescale 1ns/1ps
module single_wire_command_decoder_tb;
  // short timings keep the run brief; dw1 < dw0 < cycd and split < brk must hold
  localparam int SPLIT = 20;
  localparam int BRK = 60;
  localparam int RESP = 30;
  localparam int DW1 = 8;
  localparam int DW0 = 24;
  localparam int CYCD = 40;
  localparam int PAIR = 4000;
  logic ce;
  logic clk, reset_n, core_pair_we, core_ready, host_wr_valid, line_out, line_oe, host_low;
  logic [swcd_pkg::ADDR_W-2:0] core_pair_addr;
  logic [2*swcd_pkg::DATA_W-1:0] core_pair_data;
  logic [swcd_pkg::ADDR_W-1:0] host_wr_addr;
  logic [swcd_pkg::DATA_W-1:0] host_wr_data;
  int num_errors = 0;
  int samples_checked = 0;
  int wr_pulses = 0;
  // open drain: low when either party pulls
  wire logic line = ~(line_oe | host_low);
  // ----------------------------------------------------------------
  // clock, reset, instances
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  single_wire_command_decoder #(.SPLIT_CYC(SPLIT), .BREAK_CYC(BRK), .RESP_CYC(RESP),
    .DW1_CYC(DW1), .DW0_CYC(DW0), .CYCD_CYC(CYCD), .PAIR_CYC(PAIR))
    i_single_wire_command_decoder (
    .clk(clk), .reset_n(reset_n), .ce(ce), .line_in(line), .line_out(line_out),
    .line_oe(line_oe), .core_pair_we(core_pair_we), .core_pair_addr(core_pair_addr),
    .core_pair_data(core_pair_data), .core_ready(core_ready), .host_wr_valid(host_wr_valid),
    .host_wr_addr(host_wr_addr), .host_wr_data(host_wr_data));
  wire_host_model i_wire_host_model (.clk(clk), .line(line), .pull_low(host_low));
  // count write notifications; a stuck or doubled pulse shows as a wrong count
  always @(posedge clk) begin
    if (host_wr_valid === 1'b1) wr_pulses++;
  end
  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  logic [6:0] addrs [3] = '{7'h7f, 7'h00, 7'h2a};
  logic [7:0] datas [3] = '{8'ha5, 8'h3c, 8'h81};
  // both extreme addresses and 2a, then read back each with the response delay measured
  task automatic test_write_read();
    logic [7:0] b;
    int w, p;
    i_wire_host_model.send_break();
    for (int i = 0; i < 3; i++) begin
      p = wr_pulses;
      i_wire_host_model.write_reg(addrs[i], datas[i]);
      check("wr_pulses", 16'(wr_pulses - p), 16'h0001);
      check("wr_addr", 16'(host_wr_addr), 16'(addrs[i]));
      check("wr_data", 16'(host_wr_data), 16'(datas[i]));
    end
    for (int i = 0; i < 3; i++) begin
      i_wire_host_model.read_reg(addrs[i], b, w);
      check("rd_data", 16'(b), 16'(datas[i]));
      // host idles 12 cycles after the last bit before it starts counting
      check("resp_not_early", 16'(w + 12 >= RESP), 16'h0001);
      check("resp_not_late", 16'(w + 12 <= RESP + 12), 16'h0001);
      check("line_out", 16'(line_out), 16'h0000);
    end
    $display("test_write_read done");
  endtask : test_write_read
  // half a data byte then a break: nothing stored, old value survives
  task automatic test_abort();
    logic [7:0] b;
    int w, p;
    p = wr_pulses;
    i_wire_host_model.send_byte({1'b1, 7'h2a}, 8);
    i_wire_host_model.send_byte(8'hff, 4);
    i_wire_host_model.send_break();
    check("abort_pulses", 16'(wr_pulses - p), 16'h0000);
    i_wire_host_model.read_reg(7'h2a, b, w);
    check("abort_keep", 16'(b), 16'h0081);
    $display("test_abort done");
  endtask : test_abort
  // clock enable low: a whole write goes unseen and the old byte stays
  task automatic test_freeze();
    logic [7:0] b;
    int w, p;
    i_wire_host_model.write_reg(7'h11, 8'h66);
    p = wr_pulses;
    ce = 1'b0;
    i_wire_host_model.write_reg(7'h11, 8'h99);
    check("frozen_pulses", 16'(wr_pulses - p), 16'h0000);
    check("frozen_addr", 16'(host_wr_addr), 16'h0011);
    ce = 1'b1;
    i_wire_host_model.send_break();
    i_wire_host_model.read_reg(7'h11, b, w);
    check("frozen_keep", 16'(b), 16'h0066);
    $display("test_freeze done");
  endtask : test_freeze
  // a pair refresh, an early second refresh refused, then a coherent read
  task automatic test_pair();
    logic [15:0] v;
    logic [7:0] b;
    int n, w;
    n = 0;
    while (core_ready !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    core_pair_addr = 6'h05;
    core_pair_data = 16'hbeef;
    core_pair_we = 1'b1;
    @(negedge clk);
    core_pair_we = 1'b0;
    check("ready_low", 16'(core_ready), 16'h0000);
    repeat (3) @(negedge clk);
    core_pair_data = 16'h1234;
    core_pair_we = 1'b1;
    @(negedge clk);
    core_pair_we = 1'b0;
    i_wire_host_model.read16(6'h05, v);
    check("pair_value", v, 16'hbeef);
    i_wire_host_model.read_reg(7'h0b, b, w);
    check("pair_high", 16'(b), 16'h00be);
    $display("test_pair done");
  endtask : test_pair
  // a refresh lands after the first high read and before the second: the
  // highs differ, so the host must reread the low byte and report the new pair
  task automatic test_torn();
    logic [15:0] v;
    int n;
    n = 0;
    while (core_ready !== 1'b1 && n < 2 * PAIR) begin
      @(negedge clk);
      n++;
    end
    check("ready_back", 16'(core_ready), 16'h0001);
    fork
      i_wire_host_model.read16(6'h05, v);
      begin
        repeat (1200) @(negedge clk);
        core_pair_data = 16'h1234;
        core_pair_we = 1'b1;
        @(negedge clk);
        core_pair_we = 1'b0;
      end
    join
    check("torn_value", v, 16'h1234);
    $display("test_torn done");
  endtask : test_torn
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    core_pair_we = 1'b0;
    core_pair_addr = 6'h00;
    core_pair_data = 16'h0000;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
    test_write_read();
    test_abort();
    test_freeze();
    test_pair();
    test_torn();
    finish_test();
  end
  // the run needs about 15k cycles; triple that is a hang
  initial begin
    #(20 * 45000);
    num_errors++;
    finish_test();
  end
endmodule : single_wire_command_decoder_tb
